// ### clk_select_regs.vh
// register map, field positions, reset values and timing counts
`ifndef CLK_SELECT_REGS_VH
`define CLK_SELECT_REGS_VH

// ----------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS      50
`define FAIL_TIME_NS       2000
`define FAIL_CYCLES        (`FAIL_TIME_NS / `CLK_PERIOD_NS)
`define SWITCH_GAP_NS      200
`define SWITCH_GAP_CYCLES  ((`SWITCH_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RC_FREQ_MHZ        16

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OFS_CTRL           12'h000
`define OFS_PRESCALE       12'h004
`define OFS_STATUS         12'h008
`define OFS_INT_STATUS     12'h00c
`define OFS_INT_MASK       12'h010
`define OFS_POWER_CTRL     12'h014

// ----------------------------------------------------------------------
// fields
// ----------------------------------------------------------------------
`define SRC_RC             2'h0
`define SRC_EXT            2'h1
`define SRC_PLL            2'h2
`define CTRL_SRC_LO        0
`define CTRL_MON_EN        2
`define CTRL_EXT_EN        3
`define CTRL_PLL_EN        4
`define CTRL_PLL_SRC       5
`define PRE_AHB_LO         0
`define PRE_APB2_LO        4
`define PRE_APB1_LO        8
`define INT_EXT_FAIL       0
`define INT_PLL_FAIL       1
`define INT_SWITCH_DONE    2
`define INT_BITS           3
`define VSEL_SCALE3        2'h1
`define VSEL_SCALE2        2'h2
`define VSEL_SCALE1        2'h3

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CTRL_RESET         6'h00
`define PRESCALE_RESET     12'h000
`define INT_MASK_RESET     3'h0
`define VSEL_RESET         2'h1

`endif

// ### prescaler.v
// power-of-two clock prescaler producing a one-cycle tick
module prescaler #(
    parameter CW = 16
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire         run,
    input  wire [3:0]   div_log2,
    output reg          tick
);
    reg [CW-1:0] count_reg;
    wire [CW-1:0] last = ({{(CW-1){1'b0}}, 1'b1} << div_log2) - 1'b1;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= {CW{1'b0}};
            tick      <= 1'b0;
        end else if (!run) begin
            // held at zero during a source switch so no short period escapes
            count_reg <= {CW{1'b0}};
            tick      <= 1'b0;
        end else if (count_reg >= last) begin
            count_reg <= {CW{1'b0}};
            tick      <= 1'b1;
        end else begin
            count_reg <= count_reg + 1'b1;
            tick      <= 1'b0;
        end
    end
endmodule

// ### sysclk_select.v
// system clock source selector with failure fallback and bus prescalers
//
// Summary of operation
// - reset selects internal 16 MHz RC oscillator
// - software selects RC, external 4-26 MHz or PLL
// - external failure with monitor forces RC
// - external failure raises interrupt when enabled
// - PLL fed by chosen oscillator, selectable
// - PLL reference failure flagged as interrupt
// - separate prescalers for AHB, APB2, APB1
// - timers get doubled kernel clock when divided
//
// Local design decisions: register access over AHB-Lite and the placing of the registers.
`include "clk_select_regs.vh"
module sysclk_select #(
    parameter FAIL_CYCLES = `FAIL_CYCLES,
    parameter GAP_CYCLES  = `SWITCH_GAP_CYCLES
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire         hsel,
    input  wire [11:0]  haddr,
    input  wire [1:0]   htrans,
    input  wire         hwrite,
    input  wire [2:0]   hsize,
    input  wire [31:0]  hwdata,
    input  wire         hready,
    output reg          hreadyout,
    output reg  [31:0]  hrdata,
    output reg          hresp,
    input  wire         ext_heartbeat,
    input  wire         ext_osc_ready,
    input  wire         pll_locked,
    output reg          gate_rc,
    output reg          gate_ext,
    output reg          gate_pll,
    output reg          ext_osc_enable,
    output reg          pll_enable,
    output reg          pll_ref_ext,
    output reg  [1:0]   voltage_scale_select,
    output wire         ahb_clock_tick,
    output wire         high_speed_apb_clock,
    output wire         low_speed_apb_clock,
    output wire         timer_kernel_clock_apb2,
    output wire         timer_kernel_clock_apb1,
    output reg          irq
);

    // ------------------------------------------------------------------
    // ahb-lite slave
    // ------------------------------------------------------------------
    reg         wr_pend_reg;
    reg [11:0]  wr_addr_reg;
    wire        addr_phase = hsel && hready && htrans[1];

    reg [5:0]   ctrl_reg;
    reg [11:0]  prescale_reg;
    reg [2:0]   int_status_reg;
    reg [2:0]   int_mask_reg;
    reg [1:0]   active_src_reg;
    reg [1:0]   state_reg;
    reg         ext_failed_reg;

    function [31:0] read_mux;
        input [11:0] a;
        begin
            case (a)
                `OFS_CTRL:       read_mux = {26'h0, ctrl_reg};
                `OFS_PRESCALE:   read_mux = {20'h0, prescale_reg};
                `OFS_STATUS:     read_mux = {26'h0, ext_failed_reg,
                                             pll_locked, ext_osc_ready,
                                             state_reg != 2'h0,
                                             active_src_reg};
                `OFS_INT_STATUS: read_mux = {29'h0, int_status_reg};
                `OFS_INT_MASK:   read_mux = {29'h0, int_mask_reg};
                `OFS_POWER_CTRL: read_mux = {30'h0, voltage_scale_select};
                default:         read_mux = 32'h0;
            endcase
        end
    endfunction

    function is_write_to;
        input [11:0] a;
        input [11:0] ofs;
        begin
            is_write_to = wr_pend_reg && (a == ofs);
        end
    endfunction

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 12'h000;
            hrdata      <= 32'h0;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
        end else begin
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
            wr_pend_reg <= addr_phase && hwrite;
            if (addr_phase) begin
                wr_addr_reg <= {haddr[11:2], 2'b00};
            end
            if (addr_phase && !hwrite) begin
                hrdata <= read_mux({haddr[11:2], 2'b00});
            end
        end
    end

    // ------------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------------
    wire [1:0] req_src = ctrl_reg[`CTRL_SRC_LO+1:`CTRL_SRC_LO];
    wire       mon_en  = ctrl_reg[`CTRL_MON_EN];
    reg        hb_last_reg;
    reg [15:0] idle_cnt_reg;
    wire       hb_edge  = ext_heartbeat ^ hb_last_reg;
    wire       ext_used = ctrl_reg[`CTRL_EXT_EN];
    wire       fail_evt = ext_used && mon_en && !ext_failed_reg &&
                          (idle_cnt_reg == FAIL_CYCLES[15:0] - 16'h1);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg             <= `CTRL_RESET;
            prescale_reg         <= `PRESCALE_RESET;
            int_mask_reg         <= `INT_MASK_RESET;
            voltage_scale_select <= `VSEL_RESET;
        end else begin
            if (is_write_to(wr_addr_reg, `OFS_CTRL)) begin
                ctrl_reg <= hwdata[5:0];
            end else if (fail_evt && mon_en) begin
                // fallback also rewrites the request so it sticks
                ctrl_reg[`CTRL_SRC_LO+1:`CTRL_SRC_LO] <= `SRC_RC;
            end
            if (is_write_to(wr_addr_reg, `OFS_PRESCALE)) begin
                prescale_reg <= hwdata[11:0];
            end
            if (is_write_to(wr_addr_reg, `OFS_INT_MASK)) begin
                int_mask_reg <= hwdata[2:0];
            end
            if (is_write_to(wr_addr_reg, `OFS_POWER_CTRL)) begin
                // encoding 0 is not a valid scale; keep the old one
                if (hwdata[1:0] != 2'h0) begin
                    voltage_scale_select <= hwdata[1:0];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // external clock monitor
    // ------------------------------------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hb_last_reg    <= 1'b0;
            idle_cnt_reg   <= 16'h0;
            ext_failed_reg <= 1'b0;
        end else begin
            hb_last_reg <= ext_heartbeat;
            if (hb_edge || !ext_used || !mon_en) begin
                idle_cnt_reg   <= 16'h0;
                ext_failed_reg <= 1'b0;
            end else if (fail_evt) begin
                ext_failed_reg <= 1'b1;
            end else if (!ext_failed_reg) begin
                idle_cnt_reg <= idle_cnt_reg + 16'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // glitch-free source switch
    // ------------------------------------------------------------------
    localparam ST_RUN  = 2'h0;
    localparam ST_OFF  = 2'h1;
    localparam ST_WAIT = 2'h2;

    reg [1:0]  target_reg;
    reg [7:0]  gap_cnt_reg;
    reg        switch_done;

    // the external source is usable only once its oscillator reports ready, the pll only once pll_locked; RC always is
    function src_ok;
        input [1:0] s;
        begin
            case (s)
                `SRC_EXT: src_ok = ext_osc_ready && !ext_failed_reg;
                `SRC_PLL: src_ok = pll_locked && !(pll_ref_ext &&
                                                   ext_failed_reg);
                default:  src_ok = 1'b1;
            endcase
        end
    endfunction

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg      <= ST_RUN;
            active_src_reg <= `SRC_RC;
            target_reg     <= `SRC_RC;
            gap_cnt_reg    <= 8'h0;
            gate_rc        <= 1'b1;
            gate_ext       <= 1'b0;
            gate_pll       <= 1'b0;
            switch_done    <= 1'b0;
        end else begin
            switch_done <= 1'b0;
            case (state_reg)
                ST_RUN: begin
                    if (!src_ok(active_src_reg)) begin
                        // lost source: fall back to RC at once
                        target_reg <= `SRC_RC;
                        state_reg  <= ST_OFF;
                    end else if (req_src != active_src_reg &&
                                 req_src != 2'h3 && src_ok(req_src)) begin
                        target_reg <= req_src;
                        state_reg  <= ST_OFF;
                    end
                end
                ST_OFF: begin
                    // all gates low first, then a dead gap
                    gate_rc     <= 1'b0;
                    gate_ext    <= 1'b0;
                    gate_pll    <= 1'b0;
                    gap_cnt_reg <= 8'h0;
                    state_reg   <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (gap_cnt_reg == GAP_CYCLES[7:0] - 8'h1) begin
                        gate_rc        <= target_reg == `SRC_RC;
                        gate_ext       <= target_reg == `SRC_EXT;
                        gate_pll       <= target_reg == `SRC_PLL;
                        active_src_reg <= target_reg;
                        switch_done    <= 1'b1;
                        state_reg      <= ST_RUN;
                    end else begin
                        gap_cnt_reg <= gap_cnt_reg + 8'h1;
                    end
                end
                default: state_reg <= ST_RUN;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // oscillator and pll controls
    // ------------------------------------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_osc_enable <= 1'b0;
            pll_enable     <= 1'b0;
            pll_ref_ext    <= 1'b0;
        end else begin
            ext_osc_enable <= ctrl_reg[`CTRL_EXT_EN];
            pll_enable     <= ctrl_reg[`CTRL_PLL_EN];
            pll_ref_ext    <= ctrl_reg[`CTRL_PLL_SRC];
        end
    end

    // ------------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------------
    wire       pll_fail_evt = fail_evt && pll_ref_ext &&
                              ctrl_reg[`CTRL_PLL_EN];
    wire [2:0] set_bits = {switch_done, pll_fail_evt, fail_evt};
    wire [2:0] clr_bits = is_write_to(wr_addr_reg, `OFS_INT_STATUS) ?
                          hwdata[2:0] : 3'h0;
    // a mask write acts at the same edge as a status clear
    wire [2:0] mask_now = is_write_to(wr_addr_reg, `OFS_INT_MASK) ?
                          hwdata[2:0] : int_mask_reg;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            int_status_reg <= 3'h0;
            irq            <= 1'b0;
        end else begin
            // a set in the clearing cycle wins
            int_status_reg <= (int_status_reg & ~clr_bits) | set_bits;
            irq <= |(((int_status_reg & ~clr_bits) | set_bits) &
                     mask_now);
        end
    end

    // ------------------------------------------------------------------
    // prescalers
    // ------------------------------------------------------------------
    wire [2:0] ahb_div  = prescale_reg[`PRE_AHB_LO+2:`PRE_AHB_LO];
    wire [2:0] apb2_div = prescale_reg[`PRE_APB2_LO+2:`PRE_APB2_LO];
    wire [2:0] apb1_div = prescale_reg[`PRE_APB1_LO+2:`PRE_APB1_LO];

    // timers run at twice their bus rate whenever that bus is divided
    function [3:0] timer_div;
        input [2:0] a;
        input [2:0] p;
        begin
            timer_div = (p == 3'h0) ? {1'b0, a} :
                        {1'b0, a} + {1'b0, p} - 4'h1;
        end
    endfunction

    wire [19:0] div_vec = {timer_div(ahb_div, apb1_div),
                           timer_div(ahb_div, apb2_div),
                           {1'b0, ahb_div} + {1'b0, apb1_div},
                           {1'b0, ahb_div} + {1'b0, apb2_div},
                           {1'b0, ahb_div}};
    wire [4:0]  ticks;
    wire        run = (state_reg == ST_RUN);

    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1) begin : pre
            prescaler #(
                .CW(16)
            ) u_pre (
                .clk      (clk),
                .rst_n    (rst_n),
                .run      (run),
                .div_log2 (div_vec[4*g+3:4*g]),
                .tick     (ticks[g])
            );
        end
    endgenerate

    assign ahb_clock_tick          = ticks[0];
    assign high_speed_apb_clock    = ticks[1];
    assign low_speed_apb_clock     = ticks[2];
    assign timer_kernel_clock_apb2 = ticks[3];
    assign timer_kernel_clock_apb1 = ticks[4];

endmodule

// ### ext_clock_model.sv
// behavioural external oscillator and pll facing the clock selector
module ext_clock_model (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic alive,
    input  wire logic osc_en,
    input  wire logic pll_en,
    input  wire logic ref_ext,
    output logic      heartbeat,
    output wire logic osc_ready,
    output wire logic locked
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] ph;
    logic [1:0] up;
    logic [1:0] lk;
    assign osc_ready = (up == 2'h3);
    assign locked = (lk == 2'h3);
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ph <= 2'h0;
            up <= 2'h0;
            lk <= 2'h0;
            heartbeat <= 1'b0;
        end else begin
            ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
            // a dead source stops toggling, it does not hold a pattern
            if (alive && osc_en && ph == 2'h2)
                heartbeat <= ~heartbeat;
            up <= !osc_en ? 2'h0 : (up == 2'h3) ? up : up + 2'h1;
            // a pll fed by a dead reference loses lock, as real ones do
            if (!pll_en || (ref_ext && !alive))
                lk <= 2'h0;
            else if (lk != 2'h3)
                lk <= lk + 2'h1;
        end
    end
endmodule

// ### sysclk_select_assertions.sv
// concurrent checks on the clock selector ports
`include "clk_select_regs.vh"
module sysclk_select_chk #(
    parameter FAIL_CYCLES = 8,
    parameter GAP_CYCLES  = 2
) (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic        ext_heartbeat,
    input wire logic        ext_osc_ready,
    input wire logic        pll_locked,
    input wire logic        gate_rc,
    input wire logic        gate_ext,
    input wire logic        gate_pll,
    input wire logic        ext_osc_enable,
    input wire logic        pll_enable,
    input wire logic        pll_ref_ext,
    input wire logic [1:0]  voltage_scale_select,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic        wr_q;
    logic        mon_q;
    logic        hb_q;
    logic [11:0] a_q;
    logic [7:0]  hb_cnt;
    wire         gates_off = !gate_rc && !gate_ext && !gate_pll;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= 1'b0;
            mon_q <= 1'b0;
            hb_q <= 1'b0;
            a_q <= 12'h000;
            hb_cnt <= 8'h00;
        end else begin
            wr_q <= hsel && hready && htrans[1] && hwrite;
            a_q <= haddr;
            if (wr_q && a_q == `OFS_CTRL)
                mon_q <= hwdata[`CTRL_MON_EN];
            hb_q <= ext_heartbeat;
            // saturate so a long dead spell never wraps to a small count
            hb_cnt <= (hb_q != ext_heartbeat) ? 8'h00 :
                      (hb_cnt == 8'hff) ? hb_cnt : hb_cnt + 8'h01;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    property p_one_hot; $onehot0({gate_rc, gate_ext, gate_pll}); endproperty
    a_one_hot: assert property (p_one_hot)
        else $error("more than one source gate open");
    property p_gap;
        $rose(gate_rc) || $rose(gate_ext) || $rose(gate_pll) |->
            $past(gates_off) && $past(gates_off, 2);
    endproperty
    a_gap: assert property (p_gap)
        else $error("source gate opened without a dead gap");
    property p_vscale;
        wr_q && a_q == `OFS_POWER_CTRL && hwdata[1:0] != 2'h0 |=>
            voltage_scale_select == $past(hwdata[1:0]);
    endproperty
    a_vscale: assert property (p_vscale)
        else $error("voltage scale not taken from write");
    property p_irq_fall;
        $fell(irq) |-> $past(wr_q) &&
            ($past(a_q) == `OFS_INT_STATUS || $past(a_q) == `OFS_INT_MASK);
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("interrupt dropped without a status or mask write");
    property p_fallback;
        mon_q && ext_osc_enable && hb_cnt > FAIL_CYCLES + GAP_CYCLES + 6
            |-> !gate_ext && !(gate_pll && pll_ref_ext);
    endproperty
    a_fallback: assert property (p_fallback)
        else $error("dead external source still drives the system");
    property p_copy;
        wr_q && a_q == `OFS_CTRL |=> ##1
            ext_osc_enable == $past(hwdata[`CTRL_EXT_EN], 2) &&
            pll_enable == $past(hwdata[`CTRL_PLL_EN], 2) &&
            pll_ref_ext == $past(hwdata[`CTRL_PLL_SRC], 2);
    endproperty
    a_copy: assert property (p_copy)
        else $error("enable outputs do not follow control write");
    property p_ext_ready; $rose(gate_ext) |-> ext_osc_ready; endproperty
    a_ext_ready: assert property (p_ext_ready)
        else $error("external gate opened before oscillator ready");
    property p_pll_ready; $rose(gate_pll) |-> pll_locked; endproperty
    a_pll_ready: assert property (p_pll_ready)
        else $error("pll gate opened before lock");
endmodule
bind sysclk_select sysclk_select_chk #(
    .FAIL_CYCLES(FAIL_CYCLES), .GAP_CYCLES(GAP_CYCLES)
) u_chk (
    .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
    .ext_heartbeat(ext_heartbeat), .ext_osc_ready(ext_osc_ready),
    .pll_locked(pll_locked), .gate_rc(gate_rc), .gate_ext(gate_ext),
    .gate_pll(gate_pll), .ext_osc_enable(ext_osc_enable),
    .pll_enable(pll_enable), .pll_ref_ext(pll_ref_ext),
    .voltage_scale_select(voltage_scale_select), .irq(irq)
);

// ### tb_system_clock_selector_with_failsafe.sv
// self-checking bench for the clock selector with failure fallback
`include "clk_select_regs.vh"
module tb_system_clock_selector_with_failsafe;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst_n, hsel, hwrite, alive;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, rd;
    wire         hreadyout, hresp, hb, o_rdy, lck, g_rc, g_ext, g_pll;
    wire         o_en, p_en, p_ref, t_ahb, t_hs, t_ls, t_k2, t_k1, irq;
    wire [31:0]  hrdata;
    wire [1:0]   vsel;
    int          n_mismatch, n_checks, i;
    sysclk_select #(.FAIL_CYCLES(8), .GAP_CYCLES(2)) u_dut (
        .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .ext_heartbeat(hb), .ext_osc_ready(o_rdy),
        .pll_locked(lck), .gate_rc(g_rc), .gate_ext(g_ext),
        .gate_pll(g_pll), .ext_osc_enable(o_en), .pll_enable(p_en),
        .pll_ref_ext(p_ref), .voltage_scale_select(vsel),
        .ahb_clock_tick(t_ahb), .high_speed_apb_clock(t_hs),
        .low_speed_apb_clock(t_ls), .timer_kernel_clock_apb2(t_k2),
        .timer_kernel_clock_apb1(t_k1), .irq(irq));
    ext_clock_model u_osc (.clk(clk), .rst_n(rst_n), .alive(alive),
        .osc_en(o_en), .pll_en(p_en), .ref_ext(p_ref), .heartbeat(hb),
        .osc_ready(o_rdy), .locked(lck));
    // ------------------------------------------------------------------
    // bus and check helpers
    // ------------------------------------------------------------------
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk("hresp", {31'h0, hresp}, 32'h0);
        // let what the data edge launched settle before callers look
        @(negedge clk);
    endtask
    task rchk(input string nm, input logic [11:0] a, input logic [31:0] msk,
              input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(nm, rd & msk, exp);
    endtask
    task wait_g(input logic [2:0] g);
        for (i = 0; i < 200 && {g_pll, g_ext, g_rc} !== g; i++) @(negedge clk);
        chk("gates", {29'h0, g_pll, g_ext, g_rc}, {29'h0, g});
    endtask
    task wait_irq();
        for (i = 0; i < 200 && irq !== 1'b1; i++) @(negedge clk);
        chk("irq", {31'h0, irq}, 32'h1);
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task t_reset();
        chk("gates", {29'h0, g_pll, g_ext, g_rc}, 32'h1);
        chk("vsel", {30'h0, vsel}, {30'h0, `VSEL_RESET});
        rchk("ctrl", `OFS_CTRL, 32'hffffffff, 32'h0);
        rchk("presc", `OFS_PRESCALE, 32'hffffffff, 32'h0);
        rchk("mask", `OFS_INT_MASK, 32'hffffffff, 32'h0);
        rchk("power", `OFS_POWER_CTRL, 32'hffffffff, 32'h1);
        rchk("unmapped", 12'h018, 32'hffffffff, 32'h0);
        $display("reset test done");
    endtask
    task t_ext_fail();
        xfer(1'b1, `OFS_INT_MASK, 32'h1);
        xfer(1'b1, `OFS_CTRL, 32'h0d);
        wait_g(3'h2);
        rchk("active", `OFS_STATUS, 32'h3, 32'h1);
        rchk("done", `OFS_INT_STATUS, 32'h4, 32'h4);
        xfer(1'b1, `OFS_INT_STATUS, 32'h4);
        rchk("done clr", `OFS_INT_STATUS, 32'h7, 32'h0);
        chk("irq", {31'h0, irq}, 32'h0);
        alive <= 1'b0;
        wait_irq();
        wait_g(3'h1);
        rchk("fail", `OFS_INT_STATUS, 32'h1, 32'h1);
        rchk("src", `OFS_CTRL, 32'h3, 32'h0);
        alive <= 1'b1;
        repeat (10) @(posedge clk);
        xfer(1'b1, `OFS_INT_MASK, 32'h0);
        chk("irq", {31'h0, irq}, 32'h0);
        xfer(1'b1, `OFS_INT_MASK, 32'h1);
        chk("irq", {31'h0, irq}, 32'h1);
        xfer(1'b1, `OFS_INT_STATUS, 32'h7);
        chk("irq", {31'h0, irq}, 32'h0);
        $display("external source test done");
    endtask
    task t_pll_fail();
        xfer(1'b1, `OFS_INT_MASK, 32'h2);
        xfer(1'b1, `OFS_CTRL, 32'h3e);
        wait_g(3'h4);
        rchk("active", `OFS_STATUS, 32'h3, 32'h2);
        xfer(1'b1, `OFS_INT_STATUS, 32'h7);
        alive <= 1'b0;
        wait_irq();
        wait_g(3'h1);
        rchk("pll fail", `OFS_INT_STATUS, 32'h3, 32'h3);
        alive <= 1'b1;
        repeat (10) @(posedge clk);
        xfer(1'b1, `OFS_INT_STATUS, 32'h7);
        chk("irq", {31'h0, irq}, 32'h0);
        $display("pll test done");
    endtask
    task t_presc();
        int c[5];
        int e[5];
        c = '{0, 0, 0, 0, 0};
        e = '{32, 16, 8, 32, 16};
        xfer(1'b1, `OFS_PRESCALE, 32'h211);
        repeat (20) @(posedge clk);
        // the window is a multiple of every period, so phase cannot matter
        repeat (64) begin
            @(negedge clk);
            c[0] += t_ahb;
            c[1] += t_hs;
            c[2] += t_ls;
            c[3] += t_k2;
            c[4] += t_k1;
        end
        for (i = 0; i < 5; i++) chk("ticks", c[i], e[i]);
        $display("prescaler test done");
    endtask
    task t_vscale();
        for (int v = 1; v < 4; v++) begin
            xfer(1'b1, `OFS_POWER_CTRL, v);
            chk("vsel", {30'h0, vsel}, v);
        end
        xfer(1'b1, `OFS_POWER_CTRL, 32'h0);
        rchk("power", `OFS_POWER_CTRL, 32'h3, 32'h3);
        $display("voltage scale test done");
    endtask
    // ------------------------------------------------------------------
    // run control
    // ------------------------------------------------------------------
    task conclude();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        #1000000;
        n_mismatch++;
        conclude();
    end
    initial begin
        {rst_n, hsel, hwrite, haddr, htrans, hsize, hwdata} = '0;
        hsize = 3'h2;
        alive = 1'b1;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_ext_fail();
        t_pll_fail();
        t_presc();
        t_vscale();
        conclude();
    end
endmodule
